// *** mlx_pkg.sv ***
// Constants for the literal and bit operation executor.
// Assumes a 25 MHz APB clock and 14-bit instruction words.
package mlx_pkg;
	// APB register byte addresses
	localparam logic [11:0] ADDR_INSTR = 12'h000;
	localparam logic [11:0] ADDR_ACC = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_CTRL = 12'h00c;
	localparam logic [11:0] ADDR_PSC_CNT = 12'h010;
	localparam logic [11:0] ADDR_FILE_BASE = 12'h200;
	localparam logic [11:0] ADDR_FILE_MASK = 12'he00;
	// Status and control fields
	localparam int STAT_C = 0;
	localparam int STAT_DC = 1;
	localparam int STAT_Z = 2;
	localparam int STAT_UNSUP = 3;
	localparam int STAT_BUSY = 4;
	localparam int CTRL_PSC_TIMER = 0;
	// Reset values
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [2:0] FLAGS_RESET = 3'h0;
	localparam logic [13:0] INSTR_RESET = 14'h0000;
	// File addresses with side effects
	localparam logic [6:0] FILE_TIMER_ZERO = 7'h01;
	localparam logic [6:0] FILE_PC_LOW = 7'h02;
	// Opcode fields, upper four to six bits of the word
	localparam logic [5:0] OPC_XOR_LIT = 6'h3a;
	localparam logic [4:0] OPC_SUB_LIT = 5'h1e;
	localparam logic [4:0] OPC_ADD_LIT = 5'h1f;
	localparam logic [5:0] OPC_AND_LIT = 6'h39;
	localparam logic [5:0] OPC_AND_FILE = 6'h05;
	localparam logic [5:0] OPC_ADD_FILE = 6'h07;
	localparam logic [3:0] OPC_BIT_CLR = 4'h4;
	localparam logic [3:0] OPC_BIT_SET = 4'h5;
	// Cycles of an instruction that modifies the program counter
	localparam int PC_CHANGE_CYCLES = 2;

	typedef enum logic [1:0] {
		MLX_IDLE = 2'b00,
		MLX_EXEC = 2'b01,
		MLX_NOP = 2'b10
	} mlx_state_t;

	typedef enum logic [3:0] {
		MLX_OP_NONE = 4'h0,
		MLX_OP_XOR_LIT = 4'h1,
		MLX_OP_SUB_LIT = 4'h2,
		MLX_OP_ADD_LIT = 4'h3,
		MLX_OP_AND_LIT = 4'h4,
		MLX_OP_AND_FILE = 4'h5,
		MLX_OP_ADD_FILE = 4'h6,
		MLX_OP_BIT_CLR = 4'h7,
		MLX_OP_BIT_SET = 4'h8
	} mlx_op_t;
endpackage : mlx_pkg

// *** mlx_adder.sv ***
// Eight-bit adder with carry in, carry out and low nibble carry.
// Assumes operands are already inverted for subtraction by the caller.
`timescale 1ns/10ps
module mlx_adder (
	input wire logic [7:0] op_a,
	input wire logic [7:0] op_b,
	input wire logic carry_in,
	output logic [7:0] sum,
	output logic carry_out,
	output logic digit_carry_out
);
	logic [8:0] full;
	logic [4:0] low;

	always_comb begin
		full = {1'b0, op_a} + {1'b0, op_b} + {8'h00, carry_in};
		low = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, carry_in};
		sum = full[7:0];
		carry_out = full[8];
		digit_carry_out = low[4];
	end
endmodule : mlx_adder

// *** mlx_executor.sv ***
// Executor for literal, file arithmetic and bit operations, APB slave.
// Assumes one clock domain; software writes one instruction per transfer.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/10ps

// Function
// - Literal XOR: code 11 1010 k, accumulator gets result, zero flag only.
// - Subtract accumulator from literal, code 11 110x k, sets C, DC, Z.
// - Program counter change takes two cycles, second a no-op.
// - Timer zero count targeted (d=1 where used) clears assigned prescaler.
// - Add literal to accumulator, result to accumulator, sets C, DC, Z.
// - AND literal with accumulator into accumulator, zero flag only.
// - AND file with accumulator, d picks destination, zero flag only.
// - Add file and accumulator, d picks destination, sets C, DC, Z.
// - Bit clear forces chosen file bit to zero, flags untouched.
// - Bit set forces chosen file bit to one, flags untouched.
module mlx_executor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic prescaler_clear,
	output logic pc_changed,
	output logic nop_cycle
);
	mlx_pkg::mlx_state_t state;
	mlx_pkg::mlx_state_t next_state;
	mlx_pkg::mlx_op_t op;

	logic [13:0] instr;
	logic [7:0] acc;
	logic flag_c;
	logic flag_dc;
	logic flag_z;
	logic unsupported;
	logic psc_timer;
	logic [7:0] psc_cnt;
	logic settled;
	logic [7:0] file_mem [0:127];

	logic [6:0] faddr;
	logic [7:0] lit;
	logic [2:0] bitpos;
	logic dest_file;
	logic [7:0] fval;
	logic [7:0] result;
	logic wr_acc;
	logic wr_file;
	logic upd_arith;
	logic upd_z;
	logic [7:0] add_a;
	logic [7:0] add_b;
	logic add_cin;
	logic [7:0] add_sum;
	logic add_c;
	logic add_dc;
	logic bus_wr;
	logic file_hit;
	logic mapped;
	logic exec;
	logic pc_hit;
	logic timer_hit;

	function automatic logic is_zero(input logic [7:0] v);
		is_zero = (v == 8'h00);
	endfunction : is_zero

	function automatic mlx_pkg::mlx_op_t decode(input logic [13:0] w);
		if (w[13:8] == mlx_pkg::OPC_XOR_LIT) begin
			decode = mlx_pkg::MLX_OP_XOR_LIT;
		end else if (w[13:9] == mlx_pkg::OPC_SUB_LIT) begin
			decode = mlx_pkg::MLX_OP_SUB_LIT;
		end else if (w[13:9] == mlx_pkg::OPC_ADD_LIT) begin
			decode = mlx_pkg::MLX_OP_ADD_LIT;
		end else if (w[13:8] == mlx_pkg::OPC_AND_LIT) begin
			decode = mlx_pkg::MLX_OP_AND_LIT;
		end else if (w[13:8] == mlx_pkg::OPC_AND_FILE) begin
			decode = mlx_pkg::MLX_OP_AND_FILE;
		end else if (w[13:8] == mlx_pkg::OPC_ADD_FILE) begin
			decode = mlx_pkg::MLX_OP_ADD_FILE;
		end else if (w[13:10] == mlx_pkg::OPC_BIT_CLR) begin
			decode = mlx_pkg::MLX_OP_BIT_CLR;
		end else if (w[13:10] == mlx_pkg::OPC_BIT_SET) begin
			decode = mlx_pkg::MLX_OP_BIT_SET;
		end else begin
			decode = mlx_pkg::MLX_OP_NONE;
		end
	endfunction : decode

	assign op = decode(instr);
	assign faddr = instr[6:0];
	assign lit = instr[7:0];
	assign bitpos = instr[9:7];
	assign dest_file = instr[7];
	assign fval = file_mem[faddr];
	assign exec = (state == mlx_pkg::MLX_EXEC);

	mlx_adder u_adder (
		.op_a(add_a),
		.op_b(add_b),
		.carry_in(add_cin),
		.sum(add_sum),
		.carry_out(add_c),
		.digit_carry_out(add_dc)
	);

	// Operand steering and result selection
	always_comb begin
		add_a = acc;
		add_b = lit;
		add_cin = 1'b0;
		result = 8'h00;
		wr_acc = 1'b0;
		wr_file = 1'b0;
		upd_arith = 1'b0;
		upd_z = 1'b0;
		case (op)
			mlx_pkg::MLX_OP_XOR_LIT: begin
				result = acc ^ lit;
				wr_acc = 1'b1;
				upd_z = 1'b1;
			end
			mlx_pkg::MLX_OP_SUB_LIT: begin
				// Literal plus inverted accumulator plus one; carry is no-borrow
				add_a = lit;
				add_b = ~acc;
				add_cin = 1'b1;
				result = add_sum;
				wr_acc = 1'b1;
				upd_arith = 1'b1;
			end
			mlx_pkg::MLX_OP_ADD_LIT: begin
				result = add_sum;
				wr_acc = 1'b1;
				upd_arith = 1'b1;
			end
			mlx_pkg::MLX_OP_AND_LIT: begin
				result = acc & lit;
				wr_acc = 1'b1;
				upd_z = 1'b1;
			end
			mlx_pkg::MLX_OP_AND_FILE: begin
				result = acc & fval;
				wr_acc = ~dest_file;
				wr_file = dest_file;
				upd_z = 1'b1;
			end
			mlx_pkg::MLX_OP_ADD_FILE: begin
				add_b = fval;
				result = add_sum;
				wr_acc = ~dest_file;
				wr_file = dest_file;
				upd_arith = 1'b1;
			end
			mlx_pkg::MLX_OP_BIT_CLR: begin
				result = fval & ~(8'h01 << bitpos);
				wr_file = 1'b1;
			end
			mlx_pkg::MLX_OP_BIT_SET: begin
				result = fval | (8'h01 << bitpos);
				wr_file = 1'b1;
			end
			default: begin
				result = 8'h00;
			end
		endcase
	end

	// A file write to the low program counter byte changes flow
	assign pc_hit = exec && wr_file && (faddr == mlx_pkg::FILE_PC_LOW);
	assign timer_hit = exec && wr_file &&
		(faddr == mlx_pkg::FILE_TIMER_ZERO);

	always_comb begin
		case (state)
			mlx_pkg::MLX_IDLE: begin
				if (bus_wr && paddr == mlx_pkg::ADDR_INSTR) begin
					next_state = mlx_pkg::MLX_EXEC;
				end else begin
					next_state = mlx_pkg::MLX_IDLE;
				end
			end
			mlx_pkg::MLX_EXEC: begin
				if (pc_hit) begin
					next_state = mlx_pkg::MLX_NOP;
				end else begin
					next_state = mlx_pkg::MLX_IDLE;
				end
			end
			mlx_pkg::MLX_NOP: begin
				next_state = mlx_pkg::MLX_IDLE;
			end
			default: begin
				next_state = mlx_pkg::MLX_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= mlx_pkg::MLX_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// APB handshake; waits while busy so reads never see a half update
	assign file_hit = (paddr & mlx_pkg::ADDR_FILE_MASK) ==
		mlx_pkg::ADDR_FILE_BASE;
	assign mapped = file_hit || paddr == mlx_pkg::ADDR_INSTR ||
		paddr == mlx_pkg::ADDR_ACC || paddr == mlx_pkg::ADDR_STATUS ||
		paddr == mlx_pkg::ADDR_CTRL || paddr == mlx_pkg::ADDR_PSC_CNT;
	assign pready = psel && penable && settled &&
		(state == mlx_pkg::MLX_IDLE);
	assign pslverr = pready && !mapped;
	assign bus_wr = pready && pwrite && mapped;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settled <= 1'b0;
		end else begin
			settled <= (state == mlx_pkg::MLX_IDLE);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel) begin
			prdata <= 32'h0000_0000;
			if (file_hit) begin
				prdata[7:0] <= file_mem[paddr[8:2]];
			end else begin
				case (paddr)
					mlx_pkg::ADDR_INSTR: prdata[13:0] <= instr;
					mlx_pkg::ADDR_ACC: prdata[7:0] <= acc;
					mlx_pkg::ADDR_STATUS: begin
						prdata[mlx_pkg::STAT_C] <= flag_c;
						prdata[mlx_pkg::STAT_DC] <= flag_dc;
						prdata[mlx_pkg::STAT_Z] <= flag_z;
						prdata[mlx_pkg::STAT_UNSUP] <= unsupported;
						prdata[mlx_pkg::STAT_BUSY] <=
							(state != mlx_pkg::MLX_IDLE);
					end
					mlx_pkg::ADDR_CTRL: prdata[mlx_pkg::CTRL_PSC_TIMER] <= psc_timer;
					mlx_pkg::ADDR_PSC_CNT: prdata[7:0] <= psc_cnt;
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr <= mlx_pkg::INSTR_RESET;
			psc_timer <= 1'b0;
		end else if (bus_wr && paddr == mlx_pkg::ADDR_INSTR) begin
			instr <= pwdata[13:0];
		end else if (bus_wr && paddr == mlx_pkg::ADDR_CTRL) begin
			psc_timer <= pwdata[mlx_pkg::CTRL_PSC_TIMER];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc <= mlx_pkg::ACC_RESET;
		end else if (exec && wr_acc) begin
			acc <= result;
		end else if (bus_wr && paddr == mlx_pkg::ADDR_ACC) begin
			acc <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{flag_z, flag_dc, flag_c} <= mlx_pkg::FLAGS_RESET;
			unsupported <= 1'b0;
		end else if (exec) begin
			unsupported <= (op == mlx_pkg::MLX_OP_NONE);
			if (upd_arith) begin
				flag_c <= add_c;
				flag_dc <= add_dc;
			end
			if (upd_arith || upd_z) begin
				flag_z <= is_zero(result);
			end
		end else if (bus_wr && paddr == mlx_pkg::ADDR_STATUS) begin
			flag_c <= pwdata[mlx_pkg::STAT_C];
			flag_dc <= pwdata[mlx_pkg::STAT_DC];
			flag_z <= pwdata[mlx_pkg::STAT_Z];
		end
	end

	// Reset loop kept so file reads never return unknowns
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 128; i++) begin
				file_mem[i] <= 8'h00;
			end
		end else if (exec && wr_file) begin
			file_mem[faddr] <= result;
		end else if (bus_wr && file_hit) begin
			file_mem[paddr[8:2]] <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescaler_clear <= 1'b0;
			psc_cnt <= 8'h00;
		end else begin
			prescaler_clear <= timer_hit && psc_timer;
			if (timer_hit && psc_timer) begin
				psc_cnt <= psc_cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_changed <= 1'b0;
			nop_cycle <= 1'b0;
		end else begin
			pc_changed <= pc_hit;
			nop_cycle <= (next_state == mlx_pkg::MLX_NOP);
		end
	end
endmodule : mlx_executor

// *** mlx_executor_checker.sv ***
// Concurrent checks on the executor's outputs, bound to its ports.
// Assumes the package compiles first; one clock, async low reset.
`timescale 1ns/10ps
module mlx_executor_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic prescaler_clear,
	input wire logic pc_changed,
	input wire logic nop_cycle
);
	logic take_instr;
	assign take_instr = psel && penable && pready && pwrite
		&& paddr == mlx_pkg::ADDR_INSTR;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_nop_pair: assert property (pc_changed |-> nop_cycle)
		else $error("pc change without no-op cycle");
	chk_nop_once: assert property (nop_cycle |=> !nop_cycle)
		else $error("no-op cycle too long");
	chk_nop_cause: assert property ($rose(nop_cycle) |-> pc_changed)
		else $error("no-op cycle without pc change");
	chk_pc_cause: assert property (pc_changed |-> $past(take_instr, 2))
		else $error("pc change without instruction");
	chk_nop_stall: assert property (nop_cycle |-> !pready)
		else $error("bus answered during no-op");
	chk_exec_stall: assert property (take_instr |=> !pready [*2])
		else $error("bus answered during execution");
	chk_psc_cause: assert property (prescaler_clear |-> $past(take_instr, 2))
		else $error("prescaler clear without instruction");
	chk_psc_once: assert property (prescaler_clear |=> !prescaler_clear)
		else $error("prescaler clear not a pulse");
endmodule : mlx_executor_checker

bind mlx_executor mlx_executor_checker u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.prescaler_clear(prescaler_clear), .pc_changed(pc_changed),
	.nop_cycle(nop_cycle));

// *** testbench.sv ***
// Self-checking bench driving the executor over APB.
// Assumes package, design and checker are compiled before it.
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
	$display("BAD %0t got %h want %h", $time, a, b); end end
module testbench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, prescaler_clear, pc_changed, nop_cycle, e;
	int n_fail = 0, total_checks = 0, n_nop = 0, n_pc = 0, n_psc = 0;
	always #20 pclk = ~pclk;
	always @(posedge pclk) begin
		if (nop_cycle === 1'b1) n_nop++;
		if (pc_changed === 1'b1) n_pc++;
		if (prescaler_clear === 1'b1) n_psc++;
	end
	mlx_executor u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.prescaler_clear(prescaler_clear), .pc_changed(pc_changed),
		.nop_cycle(nop_cycle));
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 50) n_fail++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle cycle so psel is never assigned twice in one step
		@(posedge pclk);
	endtask : xfer
	function automatic logic [11:0] fa(input logic [6:0] f);
		return 12'h200 | {3'h0, f, 2'h0};
	endfunction : fa
	task automatic ex(input logic [7:0] a, input logic [2:0] s,
		input logic [6:0] f, input logic [7:0] fv, input logic [13:0] i,
		input logic [7:0] ea, input logic [2:0] es, input logic [7:0] ef);
		xfer(1'b1, fa(f), {24'h0, fv});
		xfer(1'b1, mlx_pkg::ADDR_ACC, {24'h0, a});
		xfer(1'b1, mlx_pkg::ADDR_STATUS, {29'h0, s});
		xfer(1'b1, mlx_pkg::ADDR_INSTR, {18'h0, i});
		xfer(1'b0, mlx_pkg::ADDR_ACC, 32'h0);
		`CHK(q[7:0], ea)
		xfer(1'b0, mlx_pkg::ADDR_STATUS, 32'h0);
		`CHK(q[2:0], es)
		xfer(1'b0, fa(f), 32'h0);
		`CHK(q[7:0], ef)
	endtask : ex
	task automatic t_lit;
		ex(8'h5a, 3'b011, 7'h10, 8'h00, 14'h3a5a, 8'h00, 3'b111, 8'h00);
		ex(8'hf0, 3'b100, 7'h10, 8'h00, 14'h3a0f, 8'hff, 3'b000, 8'h00);
		ex(8'h01, 3'b111, 7'h10, 8'h00, 14'h3d00, 8'hff, 3'b000, 8'h00);
		ex(8'hff, 3'b000, 7'h10, 8'h00, 14'h3e01, 8'h00, 3'b111, 8'h00);
		ex(8'hf0, 3'b011, 7'h10, 8'h00, 14'h390f, 8'h00, 3'b111, 8'h00);
		$display("literal ops done");
	endtask : t_lit
	task automatic t_file;
		ex(8'h0f, 3'b111, 7'h7f, 8'h3c, 14'h05ff, 8'h0f, 3'b011, 8'h0c);
		ex(8'h0f, 3'b111, 7'h7f, 8'h3c, 14'h057f, 8'h0c, 3'b011, 8'h3c);
		ex(8'h88, 3'b100, 7'h03, 8'h88, 14'h0703, 8'h10, 3'b011, 8'h88);
		ex(8'h88, 3'b100, 7'h03, 8'h88, 14'h0783, 8'h88, 3'b011, 8'h10);
		ex(8'h33, 3'b101, 7'h05, 8'hff, 14'h1005, 8'h33, 3'b101, 8'hfe);
		ex(8'h33, 3'b010, 7'h7f, 8'h00, 14'h17ff, 8'h33, 3'b010, 8'h80);
		$display("file ops done");
	endtask : t_file
	task automatic t_side;
		xfer(1'b1, mlx_pkg::ADDR_CTRL, 32'h1);
		ex(8'h00, 3'b000, 7'h01, 8'h05, 14'h0781, 8'h00, 3'b000, 8'h05);
		ex(8'h05, 3'b000, 7'h01, 8'h05, 14'h0701, 8'h0a, 3'b000, 8'h05);
		xfer(1'b1, mlx_pkg::ADDR_CTRL, 32'h0);
		ex(8'h00, 3'b000, 7'h01, 8'h05, 14'h0781, 8'h00, 3'b000, 8'h05);
		xfer(1'b0, mlx_pkg::ADDR_PSC_CNT, 32'h0);
		`CHK(q, 32'h1)
		`CHK(n_psc, 1)
		ex(8'h00, 3'b000, 7'h02, 8'h07, 14'h0782, 8'h00, 3'b000, 8'h07);
		ex(8'h00, 3'b000, 7'h02, 8'h07, 14'h0702, 8'h07, 3'b000, 8'h07);
		`CHK(n_nop, 1)
		`CHK(n_pc, 1)
		$display("side effects done");
	endtask : t_side
	task automatic t_err;
		xfer(1'b0, mlx_pkg::ADDR_ACC, 32'h0);
		`CHK(q, 32'h0)
		xfer(1'b0, 12'h100, 32'h0);
		`CHK({e, q}, 33'h100000000)
		xfer(1'b1, mlx_pkg::ADDR_INSTR, 32'h0);
		xfer(1'b0, mlx_pkg::ADDR_STATUS, 32'h0);
		`CHK(q, 32'h8)
		$display("reset and unmapped done");
	endtask : t_err
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_err();
		t_lit();
		t_file();
		t_side();
		finish_test();
	end
	initial begin
		repeat (5000) @(posedge pclk);
		n_fail++;
		finish_test();
	end
endmodule : testbench
